// file: samux_consts.svh
// Purpose: constants for the sdram address multiplexer
// Assumes: 16-bit bus, 8-bit column mappings only
// Notes:   setting codes follow the selection fields
`ifndef SAMUX_CONSTS_SVH
`define SAMUX_CONSTS_SVH
`define SAMUX_BSZ_16      2'h2
`define SAMUX_ROW_11      2'h0
`define SAMUX_ROW_12      2'h1
`define SAMUX_COL_8       2'h0
`define SAMUX_PIN_W       18
`define SAMUX_LADDR_W     26
`define SAMUX_ROW_SHIFT   8
`define SAMUX_AP_PIN      11
`define SAMUX_BA2_PIN     12
`define SAMUX_BA2_BIT     20
`define SAMUX_A13_BIT     21
`define SAMUX_BA4_PIN0    13
`define SAMUX_BA4_PIN1    14
`define SAMUX_BA4_BIT0    21
`define SAMUX_BA4_BIT1    22
`define SAMUX_A12_BIT     12
`define SAMUX_PIN_RESET   18'h00000
`endif

// file: samux_mem_model.sv
// Purpose: sdram side, rebuilds address
// Assumes: row before column
// Notes: none
`timescale 1ns/100ps
module samux_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic [17:0] addr_i,
  input  wire logic        row_valid_i, col_valid_i, four_i,
  output logic      [25:0] laddr_o,
  output logic             ap_o, bank_ok_o
);
  logic [17:0] row;
  always @(posedge clk_sys_i) begin
    if (row_valid_i) row <= addr_i;
    if (col_valid_i) begin
      laddr_o <= {row, addr_i[7:0]};
      ap_o <= addr_i[11];
      bank_ok_o <= four_i ? addr_i[14:13] == row[14:13] : addr_i[12] == row[12];
    end
  end
endmodule : samux_mem_model

// file: samux_pkg.sv
// Purpose: types for the sdram address multiplexer
// Assumes: constants header holds all figures
// Notes:   none
`include "samux_consts.svh"
package samux_pkg;
  typedef enum logic [1:0] {
    SAMUX_IDLE,
    SAMUX_ROW,
    SAMUX_COL
  } samux_phase_t;
  typedef struct packed {
    logic [1:0] bus_width_sel;
    logic [1:0] row_width_sel;
    logic [1:0] col_width_sel;
  } samux_cfg_t;
  typedef struct packed {
    logic                        autoprecharge;
    logic [`SAMUX_LADDR_W-1:0]   laddr;
  } samux_req_t;
endpackage : samux_pkg

// file: samux_sync.sv
// Purpose: two-stage synchroniser for pin-borne levels
// Assumes: single clock domain
// Notes:   first stage read only by the second
`timescale 1ns/100ps
module samux_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule : samux_sync

// file: samux_top.sv
// Behaviour
// - 16-bit, 11-row, 8-col: row phase drives logical bits 8..25 on A0..A17.
// - 11-row 8-col: bank select bit 20 on A12; A13 column carries bit 21.
// - 12-row 8-col: bits 21,22 bank on A13,A14; A12 column carries bit 12.
// - column phase drives A11 with the command bit, not an address bit.
// - bank bits identical on same pins in row and column phases.
//
// Purpose: sdram address multiplexer, 16-bit bus, 8-bit columns
// Assumes: request and phase strobes come from same-clock controller logic
// Notes:   configuration selects are pins, synchronised; others map to zero
`timescale 1ns/100ps
module samux_top
  import samux_pkg::*;
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        rstn_i,
  input  wire logic [1:0]                  area_bus_width_sel_i,
  input  wire logic [1:0]                  area_row_width_sel_i,
  input  wire logic [1:0]                  area_col_width_sel_i,
  input  wire logic                        row_phase_i,
  input  wire logic                        col_phase_i,
  input  wire samux_req_t                  req_i,
  output logic      [`SAMUX_PIN_W-1:0]     sdram_addr_o,
  output logic                             row_valid_o,
  output logic                             col_valid_o,
  output logic                             cfg_supported_o
);
  samux_cfg_t                   cfg;
  samux_phase_t                 next_phase;
  logic      [`SAMUX_PIN_W-1:0] next_addr;
  wire logic [`SAMUX_PIN_W-1:0] row_map;
  wire logic [`SAMUX_PIN_W-1:0] col_map;
  logic                         next_row_valid;
  logic                         next_col_valid;
  logic                         next_supported;
  logic                         bus16;
  logic                         col8;
  logic                         is_row11;
  logic                         is_row12;

  // configuration pins synchronised
  samux_sync #(
    .W (6)
  ) u_cfg_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .d_i       ({area_bus_width_sel_i, area_row_width_sel_i, area_col_width_sel_i}),
    .q_o       (cfg)
  );

  // configuration decode
  always_comb begin
    bus16          = (cfg.bus_width_sel == `SAMUX_BSZ_16);
    col8           = (cfg.col_width_sel == `SAMUX_COL_8);
    is_row11       = bus16 && col8 && (cfg.row_width_sel == `SAMUX_ROW_11);
    is_row12       = bus16 && col8 && (cfg.row_width_sel == `SAMUX_ROW_12);
    next_supported = is_row11 || is_row12;
  end

  // per-pin row and column sources
  for (genvar p = 0; p < `SAMUX_PIN_W; p++) begin : g_pin
    assign row_map[p] = req_i.laddr[p+`SAMUX_ROW_SHIFT];
    if (p == `SAMUX_AP_PIN) begin : g_cmd
      assign col_map[p] = req_i.autoprecharge;
    end else if (p == `SAMUX_BA2_PIN) begin : g_bank2
      assign col_map[p] = is_row11 ? req_i.laddr[`SAMUX_BA2_BIT] : req_i.laddr[`SAMUX_A12_BIT];
    end else if (p == `SAMUX_BA4_PIN0) begin : g_bank4_lo
      assign col_map[p] = is_row11 ? req_i.laddr[`SAMUX_A13_BIT] : req_i.laddr[`SAMUX_BA4_BIT0];
    end else if (p == `SAMUX_BA4_PIN1) begin : g_bank4_hi
      assign col_map[p] = is_row12 ? req_i.laddr[`SAMUX_BA4_BIT1] : req_i.laddr[p];
    end else begin : g_plain
      assign col_map[p] = req_i.laddr[p];
    end
  end

  // phase choice, row wins
  always_comb begin
    next_phase = SAMUX_IDLE;
    if (next_supported && row_phase_i) begin
      next_phase = SAMUX_ROW;
    end else if (next_supported && col_phase_i) begin
      next_phase = SAMUX_COL;
    end
  end

  // pin value and valid pulses
  always_comb begin
    next_addr      = sdram_addr_o;
    next_row_valid = 1'h0;
    next_col_valid = 1'h0;
    if (!next_supported) begin
      next_addr = `SAMUX_PIN_RESET;
    end else begin
      case (next_phase)
        SAMUX_ROW: begin
          next_addr      = row_map;
          next_row_valid = 1'h1;
        end
        SAMUX_COL: begin
          next_addr      = col_map;
          next_col_valid = 1'h1;
        end
        default: begin
          next_addr = sdram_addr_o;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdram_addr_o    <= `SAMUX_PIN_RESET;
      row_valid_o     <= 1'h0;
      col_valid_o     <= 1'h0;
      cfg_supported_o <= 1'h0;
    end else begin
      sdram_addr_o    <= next_addr;
      row_valid_o     <= next_row_valid;
      col_valid_o     <= next_col_valid;
      cfg_supported_o <= next_supported;
    end
  end
endmodule : samux_top

// file: samux_top_asserts.sv
// Purpose: pin map checks
// Assumes: config steady
// Notes: none
`timescale 1ns/100ps
module samux_chk
  import samux_pkg::*;
(
  input wire logic        clk_sys_i, rstn_i, row_phase_i, col_phase_i,
  input wire logic [1:0]  area_bus_width_sel_i, area_row_width_sel_i, area_col_width_sel_i,
  input wire samux_req_t  req_i,
  input wire logic [17:0] sdram_addr_o,
  input wire logic        row_valid_o, col_valid_o, cfg_supported_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  samux_req_t q;
  logic       rp, cp;
  always_ff @(posedge clk_sys_i) begin
    q <= req_i;
    rp <= row_phase_i;
    cp <= col_phase_i;
  end
  chk_row_map: assert property (row_valid_o |-> sdram_addr_o == q.laddr[25:8]) else $error("row map");
  chk_row_cause: assert property (row_valid_o |-> rp && !col_valid_o) else $error("row cause");
  chk_col_ap: assert property (col_valid_o |-> sdram_addr_o[11] == q.autoprecharge) else $error("ap bit");
  chk_col_low: assert property (col_valid_o |-> cp && !rp && sdram_addr_o[10:0] == q.laddr[10:0]
    && sdram_addr_o[17:15] == q.laddr[17:15]) else $error("col map");
  chk_bank_two: assert property (col_valid_o && area_row_width_sel_i == 2'h0
    |-> sdram_addr_o[14:12] == {q.laddr[14], q.laddr[21:20]}) else $error("two bank");
  chk_bank_four: assert property (col_valid_o && area_row_width_sel_i == 2'h1
    |-> sdram_addr_o[14:12] == {q.laddr[22:21], q.laddr[12]}) else $error("four bank");
endmodule : samux_chk

// file: tb_samux_top.sv
// Purpose: samux bench
// Assumes: strobes at falling edge
// Notes: none
`timescale 1ns/100ps
module tb_samux_top;
  import samux_pkg::*;
  logic        clk_sys_i = 0, rstn_i = 0, rp = 0, cp = 0, rv, cv, sup, ap, bok;
  logic [1:0]  bsz = 2'h2, rsel = 2'h0, csel = 2'h0;
  samux_req_t  req = '0;
  logic [17:0] addr;
  logic [25:0] la;
  int          mismatches = 0, tests_run = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  samux_top dut (.clk_sys_i, .rstn_i, .area_bus_width_sel_i(bsz), .area_row_width_sel_i(rsel),
    .area_col_width_sel_i(csel), .row_phase_i(rp), .col_phase_i(cp), .req_i(req), .sdram_addr_o(addr),
    .row_valid_o(rv), .col_valid_o(cv), .cfg_supported_o(sup));
  samux_mem_model mem (.clk_sys_i, .addr_i(addr), .row_valid_i(rv), .col_valid_i(cv), .four_i(rsel[0]),
    .laddr_o(la), .ap_o(ap), .bank_ok_o(bok));
  task chk(input logic [25:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task access(input logic a, input logic [25:0] l);
    logic [17:0] e;
    e = l[17:0];
    e[11] = a;
    if (rsel == 2'h0) e[13:12] = l[21:20];
    else e[14:12] = {l[22:21], l[12]};
    req = '{a, l};
    rp = 1;
    @(negedge clk_sys_i) rp = 0;
    cp = 1;
    @(negedge clk_sys_i) cp = 0;
    @(negedge clk_sys_i);
    chk(la, l, "laddr");
    chk(ap, a, "ap");
    chk(bok, 1'b1, "bank");
    chk(addr, e, "col");
  endtask : access
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1;
    for (int r = 0; r < 2; r++) begin
      rsel = r[1:0];
      repeat (5) @(negedge clk_sys_i);
      chk(sup, 1'h1, "sup");
      access(1'h1, 26'h07005A5);
      access(1'h0, 26'h3887FFF);
    end
    bsz = 2'h0;
    repeat (5) @(negedge clk_sys_i);
    rp = 1;
    @(negedge clk_sys_i) rp = 0;
    chk(sup, 1'h0, "unsup");
    chk(rv, 1'h0, "refused");
    chk(addr, 18'h0, "zero");
    report_and_stop();
  end
endmodule : tb_samux_top
bind samux_top samux_chk chk_i (.clk_sys_i, .rstn_i, .row_phase_i, .col_phase_i, .area_bus_width_sel_i,
  .area_row_width_sel_i, .area_col_width_sel_i, .req_i, .sdram_addr_o, .row_valid_o, .col_valid_o,
  .cfg_supported_o);
